/* File: inc/acs_regs.svh */
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ********************************************************
// register indices (byte address is four times the index)
// ********************************************************
`define ACS_IDX_SLOT_ONE 8'h91
`define ACS_IDX_SLOT_TWO 8'h92
`define ACS_IDX_ROUTE 8'hF0

// ********************************************************
// reset values
// ********************************************************
`define ACS_RST_SLOT_ONE 16'h0001
`define ACS_RST_SLOT_TWO 16'h0002

// ********************************************************
// field positions and masks
// ********************************************************
`define ACS_INCL_BIT 15
`define ACS_GAIN_HI 14
`define ACS_GAIN_LO 13
`define ACS_NEG_BIT 4
`define ACS_POS_HI 3
`define ACS_POS_LO 0
`define ACS_CFG_WMASK 16'hE01F
`define ACS_EXT_TOP 4'h7

// ********************************************************
// bus encodings
// ********************************************************
`define ACS_HSIZE_WORD 3'h2
`define ACS_HRESP_OKAY 1'b0

`endif

/* File: inc/acs_pkg.sv */
package acs_pkg;

	// converter gain after folding of the duplicate code
	typedef enum logic [1:0] {
		GAIN_X1 = 2'b00,
		GAIN_X2 = 2'b01,
		GAIN_X4 = 2'b10
	} acs_gain_t;

	// source on the converter positive input
	typedef enum logic [3:0] {
		SRC_EXTERNAL = 4'b0000,
		SRC_TEMP_SENSOR = 4'b0001,
		SRC_GROUND_SHORT = 4'b0010,
		SRC_TEST_DAC = 4'b0011,
		SRC_ANALOG_SUPPLY_DIV4 = 4'b0100,
		SRC_IO_SUPPLY_DIV4 = 4'b0101,
		SRC_CORE_SUPPLY_DIV2 = 4'b0110,
		SRC_ANALOG_POWER_DIV103 = 4'b0111,
		SRC_DIGITAL_POWER_DIV103 = 4'b1000
	} acs_src_t;

	// source on the converter negative input
	typedef enum logic [1:0] {
		NEG_GROUND = 2'b00,
		NEG_EXT_SEVEN = 2'b01,
		NEG_AUTO = 2'b10
	} acs_neg_t;

	// bus slave states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_RDLOAD = 2'b10,
		BUS_RDDONE = 2'b11
	} acs_bus_t;

	// register selected by an address phase
	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_SLOT_ONE = 2'b01,
		SEL_SLOT_TWO = 2'b10,
		SEL_ROUTE = 2'b11
	} acs_sel_t;

endpackage : acs_pkg

/* File: rtl/acs_slot_reg.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"

module acs_slot_reg #(
	parameter logic [15:0] RESET_VAL = `ACS_RST_SLOT_ONE
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// write strobe with data
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	// stored configuration
	output logic [15:0] cfg
);

	logic [15:0] cfg_ff;

	// ********************************************************
	// storage, reserved bits never take a written one
	// ********************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ff <= RESET_VAL & `ACS_CFG_WMASK;
		end else if (wr_en) begin
			cfg_ff <= wr_data & `ACS_CFG_WMASK;
		end
	end

	assign cfg = cfg_ff;

endmodule : acs_slot_reg

`default_nettype wire

/* File: rtl/acs_route_dec.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"

module acs_route_dec import acs_pkg::*; (
	// stored configuration of one slot
	input wire logic [15:0] cfg,
	// decoded routing
	output logic slot_include,
	output acs_gain_t gain,
	output logic [7:0] ext_onehot,
	output acs_src_t src,
	output acs_neg_t neg
);

	logic [3:0] pos;

	assign pos = cfg[`ACS_POS_HI:`ACS_POS_LO];
	assign slot_include = cfg[`ACS_INCL_BIT];

	// gain code, both upper codes give four
	always_comb begin
		case (cfg[`ACS_GAIN_HI:`ACS_GAIN_LO])
			2'b00: gain = GAIN_X1;
			2'b01: gain = GAIN_X2;
			default: gain = GAIN_X4;
		endcase
	end

	// positive source, internal codes force the negative input
	always_comb begin
		ext_onehot = 8'h00;
		src = SRC_EXTERNAL;
		neg = cfg[`ACS_NEG_BIT] ? NEG_EXT_SEVEN : NEG_GROUND;
		if (pos <= `ACS_EXT_TOP) begin
			ext_onehot[pos[2:0]] = 1'b1;
		end else begin
			neg = NEG_AUTO;
			case (pos)
				4'h8: src = SRC_TEMP_SENSOR;
				4'h9: src = SRC_GROUND_SHORT;
				4'hA: src = SRC_TEST_DAC;
				4'hB: src = SRC_ANALOG_SUPPLY_DIV4;
				4'hC: src = SRC_IO_SUPPLY_DIV4;
				4'hD: src = SRC_CORE_SUPPLY_DIV2;
				4'hE: src = SRC_ANALOG_POWER_DIV103;
				default: src = SRC_DIGITAL_POWER_DIV103;
			endcase
		end
	end

endmodule : acs_route_dec

`default_nettype wire

/* File: rtl/acs_slot_cfg.sv */
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"

module acs_slot_cfg import acs_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// slot one routing to the converter
	output logic slot_one_include,
	output acs_gain_t slot_one_gain_select,
	output logic [3:0] slot_one_pos_input_select,
	output acs_neg_t slot_one_neg_input_select,
	output logic [7:0] slot_one_ext_enable,
	output acs_src_t slot_one_int_source,
	// slot two routing to the converter
	output logic slot_two_include,
	output acs_gain_t slot_two_gain_select,
	output logic [3:0] slot_two_pos_input_select,
	output acs_neg_t slot_two_neg_input_select,
	output logic [7:0] slot_two_ext_enable,
	output acs_src_t slot_two_int_source
);

	localparam int NSLOT = 2;
	localparam logic [15:0] SLOT_RST [NSLOT] = '{
		`ACS_RST_SLOT_ONE, `ACS_RST_SLOT_TWO};

	// ********************************************************
	// elaboration check
	// ********************************************************
	generate
		if (ADDR_W < 10) begin : g_bad_width
			$error("address width too small for the register map");
		end
	endgenerate

	// ********************************************************
	// address decoding
	// ********************************************************
	function automatic acs_sel_t reg_sel(
		input logic [ADDR_W-1:0] a
	);
		logic [ADDR_W-3:0] idx;
		idx = a[ADDR_W-1:2];
		if (a[1:0] != 2'b00) begin
			reg_sel = SEL_NONE;
		end else if (idx == (ADDR_W-2)'(`ACS_IDX_SLOT_ONE)) begin
			reg_sel = SEL_SLOT_ONE;
		end else if (idx == (ADDR_W-2)'(`ACS_IDX_SLOT_TWO)) begin
			reg_sel = SEL_SLOT_TWO;
		end else if (idx == (ADDR_W-2)'(`ACS_IDX_ROUTE)) begin
			reg_sel = SEL_ROUTE;
		end else begin
			reg_sel = SEL_NONE;
		end
	endfunction : reg_sel

	// ********************************************************
	// bus slave state
	// ********************************************************
	acs_bus_t bus_ff;
	acs_bus_t nxt_bus;
	acs_sel_t sel_ff;
	logic size_ok_ff;
	logic accept;
	logic [31:0] hrdata_ff;
	logic [15:0] rd_word;

	// a transfer is taken when selected, active and the bus is ready
	assign accept = hsel && htrans[1] && hready;

	// next bus state, reads wait one cycle to sample fresh state
	always_comb begin
		nxt_bus = BUS_IDLE;
		case (bus_ff)
			BUS_RDLOAD: begin
				nxt_bus = BUS_RDDONE;
			end
			default: begin
				if (accept) begin
					nxt_bus = hwrite ? BUS_WRITE : BUS_RDLOAD;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_ff <= BUS_IDLE;
		end else begin
			bus_ff <= nxt_bus;
		end
	end

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_ff <= SEL_NONE;
			size_ok_ff <= 1'b0;
		end else if (accept) begin
			sel_ff <= reg_sel(haddr);
			size_ok_ff <= (hsize == `ACS_HSIZE_WORD);
		end
	end

	// only the read load cycle stretches the data phase
	assign hreadyout = (bus_ff != BUS_RDLOAD);
	assign hresp = `ACS_HRESP_OKAY;

	// ********************************************************
	// configuration slots
	// ********************************************************
	logic [15:0] cfg [NSLOT];
	logic wr_slot [NSLOT];
	logic incl [NSLOT];
	acs_gain_t gain [NSLOT];
	logic [7:0] ext [NSLOT];
	acs_src_t src [NSLOT];
	acs_neg_t neg [NSLOT];

	genvar gi;
	generate
		for (gi = 0; gi < NSLOT; gi++) begin : g_slot
			// write lands in the data phase of a word write
			assign wr_slot[gi] = (bus_ff == BUS_WRITE) && size_ok_ff &&
				(sel_ff == acs_sel_t'(2'(gi + 1)));

			acs_slot_reg #(
				.RESET_VAL(SLOT_RST[gi])
			) u_reg (
				.hclk(hclk),
				.hresetn(hresetn),
				.wr_en(wr_slot[gi]),
				.wr_data(hwdata[15:0]),
				.cfg(cfg[gi])
			);

			acs_route_dec u_dec (
				.cfg(cfg[gi]),
				.slot_include(incl[gi]),
				.gain(gain[gi]),
				.ext_onehot(ext[gi]),
				.src(src[gi]),
				.neg(neg[gi])
			);
		end
	endgenerate

	// ********************************************************
	// routing outputs
	// ********************************************************
	logic incl_ff [NSLOT];
	acs_gain_t gain_ff [NSLOT];
	logic [3:0] pos_ff [NSLOT];
	acs_neg_t neg_ff [NSLOT];
	logic [7:0] ext_ff [NSLOT];
	acs_src_t src_ff [NSLOT];

	// routing follows the stored configuration one cycle later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NSLOT; i++) begin
				incl_ff[i] <= SLOT_RST[i][`ACS_INCL_BIT];
				gain_ff[i] <= GAIN_X1;
				pos_ff[i] <= SLOT_RST[i][`ACS_POS_HI:`ACS_POS_LO];
				neg_ff[i] <= NEG_GROUND;
				ext_ff[i] <= 8'h01 << SLOT_RST[i][2:0]; // match reset code
				src_ff[i] <= SRC_EXTERNAL;
			end
		end else begin
			for (int i = 0; i < NSLOT; i++) begin
				incl_ff[i] <= incl[i];
				gain_ff[i] <= gain[i];
				pos_ff[i] <= cfg[i][`ACS_POS_HI:`ACS_POS_LO];
				neg_ff[i] <= neg[i];
				ext_ff[i] <= ext[i];
				src_ff[i] <= src[i];
			end
		end
	end

	assign slot_one_include = incl_ff[0];
	assign slot_one_gain_select = gain_ff[0];
	assign slot_one_pos_input_select = pos_ff[0];
	assign slot_one_neg_input_select = neg_ff[0];
	assign slot_one_ext_enable = ext_ff[0];
	assign slot_one_int_source = src_ff[0];
	assign slot_two_include = incl_ff[1];
	assign slot_two_gain_select = gain_ff[1];
	assign slot_two_pos_input_select = pos_ff[1];
	assign slot_two_neg_input_select = neg_ff[1];
	assign slot_two_ext_enable = ext_ff[1];
	assign slot_two_int_source = src_ff[1];

	// ********************************************************
	// read path
	// ********************************************************
	logic [2:0] ext_num;

	// index of the routed external input of slot one
	always_comb begin
		ext_num = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (ext_ff[0][i]) begin
				ext_num = 3'(i);
			end
		end
	end

	// read word, reserved bits come back as zero
	always_comb begin
		rd_word = 16'h0000;
		if (sel_ff == SEL_SLOT_ONE) begin
			rd_word = cfg[0];
		end else if (sel_ff == SEL_SLOT_TWO) begin
			rd_word = cfg[1];
		end else if (sel_ff == SEL_ROUTE) begin
			rd_word[15] = incl_ff[0];
			rd_word[14:13] = gain_ff[0];
			rd_word[11:8] = src_ff[0];
			rd_word[5:4] = neg_ff[0];
			rd_word[3] = |ext_ff[0];
			rd_word[2:0] = ext_num;
		end
	end

	// read data is loaded in the stretched cycle and held after
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h00000000;
		end else if (bus_ff == BUS_RDLOAD) begin
			hrdata_ff <= {16'h0000, rd_word};
		end
	end

	assign hrdata = hrdata_ff;

endmodule : acs_slot_cfg

`default_nettype wire

/* File: testbench/acs_slot_cfg_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bus and routing checks for slot one
// ****************************************
module acs_slot_cfg_chk import acs_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// slot one routing
	input wire acs_gain_t slot_one_gain_select,
	input wire logic [3:0] slot_one_pos_input_select,
	input wire acs_neg_t slot_one_neg_input_select,
	input wire logic [7:0] slot_one_ext_enable,
	input wire acs_src_t slot_one_int_source
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// accepted transfers and the read stretch
	sequence s_take_rd;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence s_take_wr;
		hsel && htrans[1] && hready && hwrite;
	endsequence
	sequence s_stretch;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_stretch: assert property (s_take_rd |=> s_stretch)
		else $error("read stretch is not one cycle");
	a_write_no_wait: assert property (s_take_wr |=> hreadyout)
		else $error("write data phase was stretched");
	a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved without a read");
	a_zero_bits: assert property (hreadyout |-> hrdata[31:16] == 16'h0000 && hrdata[12] == 1'b0)
		else $error("read data has bits that must be zero");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response is not okay");
	a_ext_onehot: assert property (slot_one_ext_enable == (slot_one_pos_input_select[3] ? 8'h00 : 8'h01 << slot_one_pos_input_select[2:0]))
		else $error("external enable does not match positive code");
	a_src_map: assert property (slot_one_int_source == (slot_one_pos_input_select[3] ? slot_one_pos_input_select - 4'h7 : 4'h0))
		else $error("internal source does not match positive code");
	a_neg_auto: assert property ((slot_one_neg_input_select == NEG_AUTO) == slot_one_pos_input_select[3])
		else $error("negative select not automatic exactly for internal sources");
	a_gain_fold: assert property (slot_one_gain_select != 2'h3)
		else $error("gain code three not folded");
endmodule : acs_slot_cfg_chk

bind acs_slot_cfg acs_slot_cfg_chk #(.ADDR_W(ADDR_W)) i_acs_slot_cfg_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .slot_one_gain_select(slot_one_gain_select),
	.slot_one_pos_input_select(slot_one_pos_input_select),
	.slot_one_neg_input_select(slot_one_neg_input_select),
	.slot_one_ext_enable(slot_one_ext_enable),
	.slot_one_int_source(slot_one_int_source)
);
`default_nettype wire

/* File: testbench/tb_acs_slot_cfg.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench for the slot configuration block
// ****************************************
module tb_acs_slot_cfg;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, o1_inc, o2_inc;
	logic [3:0] o1_pos, o2_pos;
	logic [7:0] o1_ext, o2_ext;
	acs_pkg::acs_gain_t o1_gain, o2_gain;
	acs_pkg::acs_neg_t o1_neg, o2_neg;
	acs_pkg::acs_src_t o1_src, o2_src;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;

	acs_slot_cfg #(.ADDR_W(12)) i_acs_slot_cfg (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .slot_one_include(o1_inc),
		.slot_one_gain_select(o1_gain), .slot_one_pos_input_select(o1_pos),
		.slot_one_neg_input_select(o1_neg), .slot_one_ext_enable(o1_ext),
		.slot_one_int_source(o1_src), .slot_two_include(o2_inc),
		.slot_two_gain_select(o2_gain), .slot_two_pos_input_select(o2_pos),
		.slot_two_neg_input_select(o2_neg), .slot_two_ext_enable(o2_ext),
		.slot_two_int_source(o2_src)
	);

	// 10 MHz clock
	always #50 hclk = ~hclk;

	// hang guard
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares = miscompares + 1;
			summarize();
		end
	end

	// ****************************************
	// bus cycle and compare tasks
	// ****************************************
	task automatic bus(input logic w, input logic [2:0] sz,
		input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= sz;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus

	task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected word at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk_bus

	task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected routing at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk_out

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		logic [31:0] r;
		chk_out(o1_pos, 8'h01);
		chk_out(o1_ext, 8'h02);
		chk_out(o1_inc, 8'h00);
		chk_out(o2_pos, 8'h02);
		chk_out(o2_ext, 8'h04);
		bus(1'b0, 3'h2, 12'h244, 32'h0, r);
		chk_bus(r, 32'h00000001);
		bus(1'b0, 3'h2, 12'h248, 32'h0, r);
		chk_bus(r, 32'h00000002);
		bus(1'b0, 3'h2, 12'h3C0, 32'h0, r);
		chk_bus(r, 32'h00000009);
	endtask : t_reset

	// every positive code, reserved bits set, upper half set
	task automatic t_codes;
		logic [31:0] r;
		logic [15:0] d;
		for (int c = 0; c < 16; c++) begin
			d = {c[0], c[1:0], 8'hFF, c[2], c[3:0]};
			bus(1'b1, 3'h2, 12'h244, {16'hFFFF, d}, r);
			bus(1'b0, 3'h2, 12'h244, 32'h0, r);
			chk_bus(r, {16'h0000, d & 16'hE01F});
			chk_out(o1_inc, c[0]);
			chk_out(o1_gain, (c[1:0] == 2'h3) ? 2'h2 : c[1:0]);
			chk_out(o1_pos, c[3:0]);
			chk_out(o1_ext, c[3] ? 8'h00 : 8'h01 << c[2:0]);
			chk_out(o1_src, c[3] ? c[3:0] - 4'h7 : 4'h0);
			chk_out(o1_neg, c[3] ? 2'h2 : {1'b0, c[2]});
		end
	endtask : t_codes

	// byte write and unmapped access leave slot one alone
	task automatic t_refused;
		logic [31:0] r;
		bus(1'b1, 3'h0, 12'h244, 32'h00008005, r);
		bus(1'b1, 3'h2, 12'h245, 32'h00008005, r);
		bus(1'b1, 3'h2, 12'h300, 32'h0000FFFF, r);
		bus(1'b0, 3'h2, 12'h300, 32'h0, r);
		chk_bus(r, 32'h0);
		chk_out(hresp, 8'h00);
		bus(1'b0, 3'h2, 12'h244, 32'h0, r);
		chk_bus(r, 32'h0000E01F);
		bus(1'b1, 3'h2, 12'h3C0, 32'h00000000, r);
		bus(1'b0, 3'h2, 12'h3C0, 32'h0, r);
		chk_bus(r, 32'h0000C820);
		bus(1'b1, 3'h2, 12'h248, 32'h0000A017, r);
		bus(1'b0, 3'h2, 12'h248, 32'h0, r);
		chk_bus(r, 32'h0000A017);
		chk_out(o2_ext, 8'h80);
		chk_out(o2_neg, 8'h01);
		chk_out(o2_gain, 8'h01);
		chk_out(o2_inc, 8'h01);
		chk_out(o2_pos, 8'h07);
		chk_out(o2_src, 8'h00);
		chk_out(o1_pos, 8'h0F);
	endtask : t_refused

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	// reset then scenarios
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_reset();
		t_codes();
		t_refused();
		summarize();
	end
endmodule : tb_acs_slot_cfg
`default_nettype wire
